// >>> logic/port_and_macrocell_regs.sv
// top: host register file for gpio ports, output macrocells and flash protect status
// Operation
// - pin input reads live pin levels
// - output latch drives pins in output mode
// - direction bit: 0 input default, 1 output
// - ports a,b,e,g drive: push-pull or open drain
// - port c drive: push-pull or slew mode
// - ports a,b,c read driver enable status
// - read input macrocell state, read-only
// - macrocell bank write loads, read returns outputs
// - mask bit 1 blocks macrocell load
// - flash protect reads one bit per sector
`timescale 1ns/1ps
module port_and_macrocell_regs
    import port_cell_pkg::*;
#(
    parameter int PORTS = PORT_CNT
)(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic [PORTS*8-1:0] pin_i,
    output logic [PORTS*8-1:0] pin_o,
    output logic [PORTS*8-1:0] pin_oe_o,
    output logic [PORTS*8-1:0] pin_slew_o,
    input wire logic [7:0] input_cell_bits_i,
    input wire logic [7:0] sector_protect_i,
    output logic [7:0] output_cell_a_bits_o,
    output logic [7:0] output_cell_b_bits_o
);
    // the map decodes exactly six ports; other counts have no addresses
    if (PORTS != PORT_CNT) begin : g_bad_ports
        $error("port_and_macrocell_regs: PORTS must equal six");
    end

    // all register-file state in one record
    typedef struct packed {
        logic [PORT_CNT-1:0][7:0] latch;
        logic [PORT_CNT-1:0][7:0] dir;
        logic [PORT_CNT-1:0][7:0] drive;
        logic [7:0] cell_a;
        logic [7:0] cell_b;
        logic [7:0] mask_a;
        logic [7:0] mask_b;
        logic [7:0] rdata;
    } regs_s;

    regs_s state_reg;
    regs_s state_next;

    logic [2:0] grp; // port or misc group
    logic [2:0] sel; // register within the group
    logic [PORT_CNT-1:0][7:0] oe_stat; // driver enables seen on the pins

    assign grp = addr_i[5:3];
    assign sel = addr_i[2:0];

    // which ports carry drive and enable-status registers
    function automatic logic has_drive(input logic [2:0] p);
        return (p == PORT_A) || (p == PORT_B) || (p == PORT_C) || (p == PORT_E) || (p == PORT_G);
    endfunction

    function automatic logic has_oe_stat(input logic [2:0] p);
        return (p == PORT_A) || (p == PORT_B) || (p == PORT_C);
    endfunction

    // masked macrocell load: masked bits keep their value
    function automatic logic [7:0] masked_load(input logic [7:0] old_v, input logic [7:0] new_v,
                                               input logic [7:0] mask);
        return (old_v & mask) | (new_v & ~mask);
    endfunction

    // per-port pin drivers
    for (genvar g = 0; g < PORT_CNT; g++) begin : g_port
        port_cfg_if cfg_if ();
        assign cfg_if.latch = state_reg.latch[g];
        assign cfg_if.dir = state_reg.dir[g];
        // port d has no drive register; it stays push-pull
        assign cfg_if.drive = (g == int'(PORT_D)) ? RST_DRIVE_TYPE : state_reg.drive[g];
        assign cfg_if.slew_port = (g == int'(PORT_C));
        port_pin_driver u_drv (
            .clk_i(clk_i),
            .arst_n_i(arst_n_i),
            .ce_i(ce_i),
            .cfg(cfg_if.sink),
            .pin_o(pin_o[g*8 +: 8]),
            .pin_oe_o(pin_oe_o[g*8 +: 8]),
            .slew_o(pin_slew_o[g*8 +: 8])
        );
        assign oe_stat[g] = pin_oe_o[g*8 +: 8];
    end

    // write decode and read mux
    always_comb begin
        state_next = state_reg;
        if (ce_i) begin
            state_next.rdata = UNMAPPED_READ; // data only in the cycle after a read
            if (wr_i) begin
                if (grp < PORT_MISC && grp <= PORT_G) begin
                    case (sel)
                        SEL_OUTPUT_LATCH: begin
                            state_next.latch[grp] = wdata_i;
                        end
                        SEL_DIRECTION: begin
                            state_next.dir[grp] = wdata_i;
                        end
                        SEL_DRIVE_TYPE: begin
                            if (has_drive(grp)) begin
                                state_next.drive[grp] = wdata_i;
                            end
                        end
                        default: begin
                            // pin input, enable status: read-only, dropped
                            state_next.rdata = UNMAPPED_READ;
                        end
                    endcase
                end else if (grp == PORT_MISC) begin
                    case (sel)
                        SEL_OUTPUT_CELL_BANK_A: begin
                            state_next.cell_a = masked_load(state_reg.cell_a, wdata_i, state_reg.mask_a);
                        end
                        SEL_OUTPUT_CELL_BANK_B: begin
                            state_next.cell_b = masked_load(state_reg.cell_b, wdata_i, state_reg.mask_b);
                        end
                        SEL_CELL_LOAD_MASK_A: begin
                            state_next.mask_a = wdata_i;
                        end
                        SEL_CELL_LOAD_MASK_B: begin
                            state_next.mask_b = wdata_i;
                        end
                        default: begin
                            // input cells, flash protect: read-only
                            state_next.rdata = UNMAPPED_READ;
                        end
                    endcase
                end
            end else if (rd_i) begin
                if (grp <= PORT_G) begin
                    case (sel)
                        SEL_PIN_INPUT: begin
                            state_next.rdata = pin_i[grp*8 +: 8];
                        end
                        SEL_OUTPUT_LATCH: begin
                            state_next.rdata = state_reg.latch[grp];
                        end
                        SEL_DIRECTION: begin
                            state_next.rdata = state_reg.dir[grp];
                        end
                        SEL_DRIVE_TYPE: begin
                            state_next.rdata = has_drive(grp) ? state_reg.drive[grp] : UNMAPPED_READ;
                        end
                        SEL_OUTPUT_ENABLE_STATUS: begin
                            state_next.rdata = has_oe_stat(grp) ? oe_stat[grp] : UNMAPPED_READ;
                        end
                        default: begin
                            state_next.rdata = UNMAPPED_READ;
                        end
                    endcase
                end else if (grp == PORT_MISC) begin
                    case (sel)
                        SEL_INPUT_CELL_STATE: begin
                            state_next.rdata = input_cell_bits_i;
                        end
                        SEL_OUTPUT_CELL_BANK_A: begin
                            state_next.rdata = state_reg.cell_a;
                        end
                        SEL_OUTPUT_CELL_BANK_B: begin
                            state_next.rdata = state_reg.cell_b;
                        end
                        SEL_CELL_LOAD_MASK_A: begin
                            state_next.rdata = state_reg.mask_a;
                        end
                        SEL_CELL_LOAD_MASK_B: begin
                            state_next.rdata = state_reg.mask_b;
                        end
                        SEL_MAIN_FLASH_SECTOR_PROTECT: begin
                            state_next.rdata = sector_protect_i;
                        end
                        default: begin
                            state_next.rdata = UNMAPPED_READ;
                        end
                    endcase
                end
            end
        end
    end

    // state register; clock enable low freezes everything
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg.latch <= {PORT_CNT{RST_OUTPUT_LATCH}};
            state_reg.dir <= {PORT_CNT{RST_DIRECTION}};
            state_reg.drive <= {PORT_CNT{RST_DRIVE_TYPE}};
            state_reg.cell_a <= RST_OUTPUT_CELL;
            state_reg.cell_b <= RST_OUTPUT_CELL;
            state_reg.mask_a <= RST_CELL_LOAD_MASK;
            state_reg.mask_b <= RST_CELL_LOAD_MASK;
            state_reg.rdata <= UNMAPPED_READ;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata_o = state_reg.rdata;
    assign output_cell_a_bits_o = state_reg.cell_a;
    assign output_cell_b_bits_o = state_reg.cell_b;
endmodule

// >>> logic/port_cell_pkg.sv
// package: register map, field widths and reset values of the port and macrocell block
package port_cell_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int PORT_CNT = 6;
    // port index encoding within address bits [5:3]
    localparam logic [2:0] PORT_A = 3'h0;
    localparam logic [2:0] PORT_B = 3'h1;
    localparam logic [2:0] PORT_C = 3'h2;
    localparam logic [2:0] PORT_D = 3'h3;
    localparam logic [2:0] PORT_E = 3'h4;
    localparam logic [2:0] PORT_G = 3'h5;
    localparam logic [2:0] PORT_MISC = 3'h7;
    // per-port register selects in address bits [2:0]
    localparam logic [2:0] SEL_PIN_INPUT = 3'h0;
    localparam logic [2:0] SEL_OUTPUT_LATCH = 3'h1;
    localparam logic [2:0] SEL_DIRECTION = 3'h2;
    localparam logic [2:0] SEL_DRIVE_TYPE = 3'h3;
    localparam logic [2:0] SEL_OUTPUT_ENABLE_STATUS = 3'h4;
    // block-wide registers in the misc group
    localparam logic [2:0] SEL_INPUT_CELL_STATE = 3'h0;
    localparam logic [2:0] SEL_OUTPUT_CELL_BANK_A = 3'h1;
    localparam logic [2:0] SEL_OUTPUT_CELL_BANK_B = 3'h2;
    localparam logic [2:0] SEL_CELL_LOAD_MASK_A = 3'h3;
    localparam logic [2:0] SEL_CELL_LOAD_MASK_B = 3'h4;
    localparam logic [2:0] SEL_MAIN_FLASH_SECTOR_PROTECT = 3'h5;
    // reset values
    localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_DRIVE_TYPE = 8'h00;
    localparam logic [7:0] RST_OUTPUT_CELL = 8'h00;
    localparam logic [7:0] RST_CELL_LOAD_MASK = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// >>> logic/port_cfg_if.sv
// interface: per-port configuration carried from the top to the pin driver
`timescale 1ns/1ps
interface port_cfg_if;
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] drive;
    logic slew_port;
    modport source (output latch, output dir, output drive, output slew_port);
    modport sink (input latch, input dir, input drive, input slew_port);
endinterface

// >>> logic/port_pin_driver.sv
// pin driver: turns one port's configuration into registered pin drive and enables
`timescale 1ns/1ps
module port_pin_driver
    import port_cell_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    port_cfg_if.sink cfg,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_o,
    output logic [7:0] slew_o
);
    // all driver state in one record
    typedef struct packed {
        logic [7:0] pin;
        logic [7:0] oe;
        logic [7:0] slew;
    } drv_s;

    drv_s state_reg;
    drv_s state_next;

    // open drain drives only the low level; push-pull drives both
    always_comb begin
        state_next = state_reg;
        if (ce_i) begin
            state_next.pin = cfg.latch;
            if (cfg.slew_port) begin
                state_next.oe = cfg.dir;
                state_next.slew = cfg.drive & cfg.dir;
            end else begin
                state_next.oe = cfg.dir & ~(cfg.drive & cfg.latch);
                state_next.slew = 8'h00;
            end
        end
    end

    // register stage, outputs straight from flops
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pin_o = state_reg.pin;
    assign pin_oe_o = state_reg.oe;
    assign slew_o = state_reg.slew;
endmodule

// >>> verif/port_cell_monitor.sv
// checker: register and pin relations seen at the block's top ports
`timescale 1ns/1ps
module port_cell_monitor
    import port_cell_pkg::*;
#(
    parameter int PORTS = PORT_CNT
)(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic [PORTS*8-1:0] pin_i,
    input wire logic [PORTS*8-1:0] pin_oe_o,
    input wire logic [PORTS*8-1:0] pin_slew_o,
    input wire logic [7:0] input_cell_bits_i,
    input wire logic [7:0] sector_protect_i,
    input wire logic [7:0] output_cell_a_bits_o,
    input wire logic [7:0] output_cell_b_bits_o
);
    // a taken read, never beside a write since writes win
    wire logic rd_ok = ce_i && rd_i && !wr_i;
    wire logic wr_ok = ce_i && wr_i;
    wire logic [2:0] grp = addr_i[5:3];
    logic [7:0] mask_a_seen; // bank a load mask as last written over the bus
    // shadow of the bank a mask, so a load can be judged bit by bit
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mask_a_seen <= RST_CELL_LOAD_MASK;
        end else if (wr_ok && addr_i == {PORT_MISC, SEL_CELL_LOAD_MASK_A}) begin
            mask_a_seen <= wdata_i;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    AST_PIN_IN: assert property (rd_ok && grp < 3'h6 && addr_i[2:0] == SEL_PIN_INPUT
        |=> rdata_o == 8'($past(pin_i >> {grp, 3'h0}))) else $error("pin input read wrong");
    AST_OE_STAT: assert property (rd_ok && grp < 3'h3 && addr_i[2:0] == SEL_OUTPUT_ENABLE_STATUS
        && $stable(pin_oe_o) |=> rdata_o == 8'($past(pin_oe_o >> {grp, 3'h0}))) else $error("enable status wrong");
    AST_CELL_IN: assert property (rd_ok && addr_i == {PORT_MISC, SEL_INPUT_CELL_STATE}
        |=> rdata_o == $past(input_cell_bits_i)) else $error("input cell read wrong");
    AST_PROTECT: assert property (rd_ok && addr_i == {PORT_MISC, SEL_MAIN_FLASH_SECTOR_PROTECT}
        |=> rdata_o == $past(sector_protect_i)) else $error("sector protect read wrong");
    AST_CELL_A_RD: assert property (rd_ok && addr_i == {PORT_MISC, SEL_OUTPUT_CELL_BANK_A}
        |=> rdata_o == $past(output_cell_a_bits_o)) else $error("cell bank a read wrong");
    AST_CELL_A_LOAD: assert property (wr_ok && addr_i == {PORT_MISC, SEL_OUTPUT_CELL_BANK_A}
        |=> output_cell_a_bits_o == (($past(output_cell_a_bits_o) & $past(mask_a_seen))
        | ($past(wdata_i) & ~$past(mask_a_seen)))) else $error("cell bank a bit neither loaded nor kept");
    AST_CELL_B_HOLD: assert property (!(wr_ok && addr_i == {PORT_MISC, SEL_OUTPUT_CELL_BANK_B})
        |=> $stable(output_cell_b_bits_o)) else $error("cell bank b changed without write");
    AST_DIR_IN: assert property (wr_ok && addr_i == {PORT_B, SEL_DIRECTION} && wdata_i == 8'h00
        ##1 !wr_i && ce_i |=> pin_oe_o[15:8] == 8'h00) else $error("input pins still driven");
    AST_SLEW_C: assert property (pin_slew_o[15:0] == 16'h0000
        && pin_slew_o[47:24] == 24'h000000) else $error("slew flag outside port c");
endmodule
bind port_and_macrocell_regs port_cell_monitor #(.PORTS(PORTS)) mon (.clk_i, .arst_n_i, .ce_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_i, .pin_oe_o, .pin_slew_o, .input_cell_bits_i, .sector_protect_i,
    .output_cell_a_bits_o, .output_cell_b_bits_o);

// >>> verif/host_model.sv
// host model: byte-wide register bus master
`timescale 1ns/1ps
module host_model
    import port_cell_pkg::*;
(
    input wire logic clk_i,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [DATA_W-1:0] rdata_i
);
    // idle bus at time zero
    initial begin
        addr_o = 6'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // leading edge wait keeps a gap, so a strobe is never set twice in one step
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask
    // read data stands only in the cycle after the taking edge
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(posedge clk_i);
        d = rdata_i;
    endtask
endmodule

// >>> verif/port_and_macrocell_regs_bench.sv
// bench: reset, pin, macrocell and read-only scenarios
`timescale 1ns/1ps
module port_and_macrocell_regs_bench
    import port_cell_pkg::*;
;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, rv, cell_a, cell_b;
    logic wr, rd;
    logic [47:0] pin_i, pin_o, pin_oe, pin_slew;
    logic [47:0] ext = 48'h0;
    logic [7:0] cells_in = 8'h00;
    logic [7:0] protect = 8'h00;
    logic ce = 1'b1;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #5 clk_i = ~clk_i;
    // driven bits follow the block, released ones the outside
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext);
    port_and_macrocell_regs #(.PORTS(6)) DUT (.clk_i, .arst_n_i, .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pin_i, .pin_o, .pin_oe_o(pin_oe), .pin_slew_o(pin_slew),
        .input_cell_bits_i(cells_in), .sector_protect_i(protect), .output_cell_a_bits_o(cell_a),
        .output_cell_b_bits_o(cell_b));
    host_model host (.clk_i, .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task automatic rdc(input string nm, input logic [5:0] a, input logic [7:0] e);
        host.rd(a, rv);
        cmp(nm, e, rv);
    endtask
    // pins lag a register write by one edge; two give margin
    task automatic settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    // defaults: inputs, push-pull, tri-state, loads allowed
    task automatic t_reset;
        rdc("dir", {PORT_E, SEL_DIRECTION}, 8'h00);
        rdc("drive", {PORT_G, SEL_DRIVE_TYPE}, 8'h00);
        rdc("drive_c", {PORT_C, SEL_DRIVE_TYPE}, 8'h00);
        rdc("oe_stat", {PORT_B, SEL_OUTPUT_ENABLE_STATUS}, 8'h00);
        rdc("mask_b", {PORT_MISC, SEL_CELL_LOAD_MASK_B}, 8'h00);
    endtask
    // every port: input, output, drive type, release
    task automatic t_pins;
        logic [2:0] p;
        for (int k = 0; k < 6; k++) begin
            p = 3'(k);
            ext[k*8 +: 8] <= 8'hA5 ^ 8'(k);
            host.wr({p, SEL_PIN_INPUT}, 8'hFF);
            rdc("pin_in", {p, SEL_PIN_INPUT}, 8'hA5 ^ 8'(k));
            host.wr({p, SEL_OUTPUT_LATCH}, 8'h3C);
            host.wr({p, SEL_DIRECTION}, 8'hFF);
            settle;
            cmp("pin_o", 8'h3C, pin_o[k*8 +: 8]);
            cmp("pin_oe", 8'hFF, pin_oe[k*8 +: 8]);
            if (k < 3) begin
                host.wr({p, SEL_OUTPUT_ENABLE_STATUS}, 8'h00);
                rdc("oe_stat", {p, SEL_OUTPUT_ENABLE_STATUS}, 8'hFF);
            end
            host.wr({p, SEL_DRIVE_TYPE}, 8'hFF);
            settle;
            // open drain drives only the low bits; port d has no drive type
            cmp("drive_oe", (k == 2 || k == 3) ? 8'hFF : 8'hC3, pin_oe[k*8 +: 8]);
            cmp("slew", (k == 2) ? 8'hFF : 8'h00, pin_slew[k*8 +: 8]);
            host.wr({p, SEL_DIRECTION}, 8'h00);
            settle;
            cmp("released", 8'h00, pin_oe[k*8 +: 8]);
        end
    endtask
    // masked bits keep their value, the rest load
    task automatic t_cells;
        host.wr({PORT_MISC, SEL_CELL_LOAD_MASK_A}, 8'h0F);
        host.wr({PORT_MISC, SEL_CELL_LOAD_MASK_B}, 8'hF0);
        host.wr({PORT_MISC, SEL_OUTPUT_CELL_BANK_A}, 8'hFF);
        host.wr({PORT_MISC, SEL_OUTPUT_CELL_BANK_B}, 8'hFF);
        rdc("cell_a", {PORT_MISC, SEL_OUTPUT_CELL_BANK_A}, 8'hF0);
        rdc("cell_b", {PORT_MISC, SEL_OUTPUT_CELL_BANK_B}, 8'h0F);
        cmp("cell_a_out", 8'hF0, cell_a);
        cmp("cell_b_out", 8'h0F, cell_b);
        rdc("mask_a", {PORT_MISC, SEL_CELL_LOAD_MASK_A}, 8'h0F);
        host.wr({PORT_MISC, SEL_CELL_LOAD_MASK_A}, 8'h00);
        host.wr({PORT_MISC, SEL_OUTPUT_CELL_BANK_A}, 8'h5A);
        rdc("cell_a", {PORT_MISC, SEL_OUTPUT_CELL_BANK_A}, 8'h5A);
    endtask
    // read-only places ignore writes; unmapped reads idle
    task automatic t_ro;
        cells_in <= 8'h5A;
        protect <= 8'h81;
        host.wr({PORT_MISC, SEL_INPUT_CELL_STATE}, 8'hFF);
        host.wr({PORT_MISC, SEL_MAIN_FLASH_SECTOR_PROTECT}, 8'h00);
        cmp("cell_ro", 8'h5A, cell_a);
        rdc("cells_in", {PORT_MISC, SEL_INPUT_CELL_STATE}, 8'h5A);
        rdc("protect", {PORT_MISC, SEL_MAIN_FLASH_SECTOR_PROTECT}, 8'h81);
        protect <= 8'h7E;
        rdc("protect", {PORT_MISC, SEL_MAIN_FLASH_SECTOR_PROTECT}, 8'h7E);
        rdc("unmapped", 6'h30, UNMAPPED_READ);
    endtask
    // clock enable low drops a write; a mid-run reset brings defaults back
    task automatic t_hold;
        host.wr({PORT_A, SEL_DIRECTION}, 8'hFF);
        ce <= 1'b0;
        host.wr({PORT_MISC, SEL_OUTPUT_CELL_BANK_A}, 8'h00);
        ce <= 1'b1;
        rdc("cell_a_held", {PORT_MISC, SEL_OUTPUT_CELL_BANK_A}, 8'h5A);
        cmp("oe_before", 8'hC3, pin_oe[7:0]);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        cmp("oe_rst", 8'h00, pin_oe[7:0]);
        rdc("dir_rst", {PORT_A, SEL_DIRECTION}, RST_DIRECTION);
        rdc("cell_a_rst", {PORT_MISC, SEL_OUTPUT_CELL_BANK_A}, RST_OUTPUT_CELL);
    endtask
    task automatic results;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_reset;
        t_pins;
        t_cells;
        t_ro;
        t_hold;
        results;
    end
    // hang guard
    initial begin
        #100000;
        n_mismatch++;
        results;
    end
endmodule
